// File: inc/chic_pkg.sv
// Purpose: Shared types and constants for the processor control-pin block.
// Assumes: One 250 MHz clock; all pin-facing inputs are asynchronous.
// Notes:   Floating-point opcode classes are pre-decoded by the core.
package chic_pkg;

  // Floating-point instruction classes seen by the bypass gate
  typedef enum logic [2:0] {
    CHIC_OP_REINIT  = 3'h0,  // Reinit
    CHIC_OP_EXCCLR  = 3'h1,  // Clear faults
    CHIC_OP_ENVST   = 3'h2,  // Store environment
    CHIC_OP_SAVE    = 3'h3,  // Save state
    CHIC_OP_STATST  = 3'h4,  // Store status word
    CHIC_OP_CTRLST  = 3'h5,  // Store control word
    CHIC_OP_OTHER   = 3'h6   // Any other numeric op
  } chic_fpu_op_t;

  // Bus ownership state
  typedef enum logic [1:0] {
    CHIC_BUS_OWN    = 2'h0,  // Driving the bus
    CHIC_BUS_DRAIN  = 2'h1,  // Finishing outstanding cycles
    CHIC_BUS_YIELD  = 2'h2   // Floated, grant high
  } chic_bus_state_t;

  // Interrupt acknowledge sequencer state
  typedef enum logic [2:0] {
    CHIC_IRQ_IDLE   = 3'h0,  // Waiting for request
    CHIC_IRQ_ACK1   = 3'h1,  // First acknowledge cycle
    CHIC_IRQ_ACK2   = 3'h2,  // Second acknowledge cycle
    CHIC_IRQ_VECT   = 3'h3,  // Vector to handler
    CHIC_IRQ_GAP    = 3'h4   // Lock negated between sequences
  } chic_irq_state_t;

  // Floating-point issue request from the core
  typedef struct packed {
    logic         valid;     // Op presented this cycle
    chic_fpu_op_t op;        // Op class
  } chic_fpu_req_t;

  // Bus cycle request from the core
  typedef struct packed {
    logic pending;           // Cycle waiting to start
    logic locked;            // Part of an atomic sequence
    logic last;              // Last cycle of a locked sequence
  } chic_bus_req_t;

  localparam logic       CHIC_MODE_NATIVE = 1'h1;  // Native fault reporting value
  localparam logic [1:0] CHIC_SYNC_RESET  = 2'h0;  // Synchroniser reset value

endpackage

// File: hdl/chic_ctrl.sv
// Purpose: Processor external control pins: bus yield, branch pulse,
//          internal error/shutdown, numeric bypass, warm restart, irq ack.
// Assumes: Core supplies decoded events; pin inputs are asynchronous.
// Notes:   Acknowledge cycles borrow the bus request path of the core.
// What this block does
// - Drain cycles, then float and raise yield grant in the same clock
// - Stay floated while request held; then release
// - Pending cycle starts as grant falls
// - No yield during locked sequences
// - Yield request honoured while reset active
// - Branch pulse one clock, always driven
// - Parity error: error flag one clock, shutdown
// - Native mode ignores numeric bypass input
// - Bypass asserted lets numeric ops continue
// - Six control ops run despite pending fault
// - Other ops halt until external interrupt, outside native mode only
// - Warm restart clears irq sequencer, halt and shutdown
// - Restart high at reset release: self test
// - Allowed irq: two locked acks, then vector
// - Lock spans sequence; one clock gap after
`timescale 1ns/100ps
module chic_ctrl
  import chic_pkg::*;
(
  input  wire logic          clock,                  // 250 MHz clock
  input  wire logic          rstn,                   // Async reset, active low
  input  wire logic          bus_yield_req,          // Pin: yield request
  output logic               bus_yield_grant,        // Pin: yield granted
  output logic               bus_float,              // High while pins floated
  input  wire chic_bus_req_t core_bus,               // Core bus request
  input  wire logic          burst_ready_in_n,       // Pin: cycle done, low
  output logic               bus_cycle_start,        // Start a bus cycle
  output logic               bus_lock_n,             // Lock indication, low
  output logic               irq_ack_cycle,          // Current cycle is an ack
  input  wire logic          branch_taken,           // Core branch event
  output logic               branch_taken_pulse,     // Pin: branch taken
  input  wire logic          array_parity_err,       // Core parity error event
  output logic               internal_error_flag_n,  // Pin: internal error, low
  output logic               shutdown,               // Shutdown state
  input  wire logic          fpu_fault_report_mode,  // Native fault mode bit
  input  wire logic          pending_fpu_fault,      // Unmasked fault pending
  input  wire logic          numeric_error_bypass_n, // Pin: bypass, low
  input  wire chic_fpu_req_t fpu_req,                // Numeric op request
  output logic               fpu_issue_ok,           // Op may execute
  output logic               fpu_halted,             // Waiting for interrupt
  input  wire logic          warm_restart,           // Pin: warm restart
  output logic               warm_restart_req,       // Pulse: restart core
  output logic               self_test_req,          // Run self test
  input  wire logic          maskable_irq_in,        // Pin: maskable irq
  input  wire logic          irq_allow,              // Interrupt-allow flag
  input  wire logic          insn_done,              // Current insn complete
  output logic               irq_vector              // Pulse: vector to handler
);

  // Reset release synchroniser
  logic [1:0] rst_sync_reg;   // Two-stage reset release
  logic       rst_n;          // Internal reset
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= CHIC_SYNC_RESET;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'h1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Pin input synchronisers, no reset so they run through reset
  logic [4:0] pin_s1_reg;     // First stage
  logic [4:0] pin_s2_reg;     // Second stage
  always_ff @(posedge clock) begin
    pin_s1_reg <= {bus_yield_req, burst_ready_in_n, numeric_error_bypass_n,
                   warm_restart, maskable_irq_in};
    pin_s2_reg <= pin_s1_reg;
  end
  logic yreq_s;               // Yield request
  logic burst_ready_in_n_s;               // Burst ready, active low
  logic bypass_n_s;           // Bypass, active low
  logic warm_s;               // Warm restart
  logic irq_s;                // Maskable irq
  assign {yreq_s, burst_ready_in_n_s, bypass_n_s, warm_s, irq_s} = pin_s2_reg;

  // Warm restart edge: tracks through reset, so release shows no false edge
  logic warm_d_reg;           // Last warm restart sample
  logic restart;              // Internal restart pulse
  always_ff @(posedge clock) begin
    warm_d_reg <= warm_s;
  end
  assign restart          = warm_s && !warm_d_reg && rst_n;
  assign warm_restart_req = restart;

  // Self test strap caught in the first clock after reset release
  logic strap_done_reg;       // Strap already sampled
  logic self_test_reg;        // Self test requested
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      strap_done_reg <= 1'h0;
      self_test_reg  <= 1'h0;
    end else if (!strap_done_reg) begin
      strap_done_reg <= 1'h1;
      self_test_reg  <= warm_s;
    end
  end
  assign self_test_req = self_test_reg;

  // Yield has no async reset: the pin is followed even while reset is held
  chic_bus_state_t bus_reg;   // Bus ownership
  logic            busy_reg;  // A bus cycle is in flight
  logic            lock_reg;  // Locked sequence active
  logic            ack_pend;  // Ack sequencer wants the bus
  logic            start;     // Start a cycle this clock
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      // During reset no cycles are outstanding
      bus_reg <= yreq_s ? CHIC_BUS_YIELD : CHIC_BUS_OWN;
    end else begin
      unique case (bus_reg)
        CHIC_BUS_OWN: begin
          if (yreq_s && !lock_reg) begin
            bus_reg <= CHIC_BUS_DRAIN;
          end
        end
        CHIC_BUS_DRAIN: begin
          if (!busy_reg || !burst_ready_in_n_s) begin
            bus_reg <= CHIC_BUS_YIELD;
          end
        end
        CHIC_BUS_YIELD: begin
          if (!yreq_s) begin
            bus_reg <= CHIC_BUS_OWN;
          end
        end
        default: bus_reg <= CHIC_BUS_OWN;
      endcase
    end
  end
  // Grant drops in the clock in which a pending cycle starts
  assign bus_yield_grant = (bus_reg == CHIC_BUS_YIELD) && yreq_s;
  assign bus_float       = bus_yield_grant;

  // A cycle may start while owning the bus, or the clock grant drops
  logic can_start;            // Bus free for a new cycle
  assign can_start = ((bus_reg == CHIC_BUS_OWN && !(yreq_s && !lock_reg)) ||
                      (bus_reg == CHIC_BUS_YIELD && !yreq_s)) &&
                     (!busy_reg || !burst_ready_in_n_s) && rst_n;
  assign start           = can_start && (core_bus.pending || ack_pend);
  assign bus_cycle_start = start;

  // Outstanding cycle tracker
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy_reg <= 1'h0;
    end else if (start) begin
      busy_reg <= 1'h1;
    end else if (!burst_ready_in_n_s) begin
      busy_reg <= 1'h0;
    end
  end

  // Interrupt acknowledge sequencer
  chic_irq_state_t irq_reg;   // Sequencer state
  logic            ack_cyc;   // Ack cycle starting this clock
  logic            ack_fired_reg;  // Current ack cycle issued
  // One ack per state: no reissue once fired
  assign ack_pend = (irq_reg == CHIC_IRQ_ACK1 || irq_reg == CHIC_IRQ_ACK2) && !busy_reg &&
                    !ack_fired_reg;
  assign ack_cyc  = ack_pend && start;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg       <= CHIC_IRQ_IDLE;
      ack_fired_reg <= 1'h0;
    end else if (restart) begin
      irq_reg       <= CHIC_IRQ_IDLE;
      ack_fired_reg <= 1'h0;
    end else begin
      unique case (irq_reg)
        CHIC_IRQ_IDLE: begin
          if (irq_s && irq_allow && insn_done && !lock_reg) begin
            irq_reg <= CHIC_IRQ_ACK1;
          end
        end
        CHIC_IRQ_ACK1: begin
          if (ack_cyc) begin
            ack_fired_reg <= 1'h1;
          end else if (ack_fired_reg && !busy_reg) begin
            ack_fired_reg <= 1'h0;
            irq_reg       <= CHIC_IRQ_ACK2;
          end
        end
        CHIC_IRQ_ACK2: begin
          if (ack_cyc) begin
            ack_fired_reg <= 1'h1;
          end else if (ack_fired_reg && !busy_reg) begin
            ack_fired_reg <= 1'h0;
            irq_reg       <= CHIC_IRQ_VECT;
          end
        end
        CHIC_IRQ_VECT: irq_reg <= CHIC_IRQ_GAP;
        CHIC_IRQ_GAP:  irq_reg <= CHIC_IRQ_IDLE;
        default:       irq_reg <= CHIC_IRQ_IDLE;
      endcase
    end
  end
  assign irq_ack_cycle = ack_cyc;
  assign irq_vector    = (irq_reg == CHIC_IRQ_VECT);

  // Lock: from first locked cycle start until ready of the last one
  logic lock_last_reg;        // Last locked cycle in flight
  logic ack_seq;              // Ack sequence in progress
  assign ack_seq = (irq_reg == CHIC_IRQ_ACK1 || irq_reg == CHIC_IRQ_ACK2);
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lock_reg      <= 1'h0;
      lock_last_reg <= 1'h0;
    end else if (lock_last_reg && busy_reg && !burst_ready_in_n_s) begin
      lock_reg      <= 1'h0;
      lock_last_reg <= 1'h0;
    end else if (start && ((core_bus.locked && !ack_pend) || ack_pend)) begin
      lock_reg      <= 1'h1;
      lock_last_reg <= ack_pend ? (irq_reg == CHIC_IRQ_ACK2) : core_bus.last;
    end
  end
  // Lock shows in the first clock of the first locked cycle
  assign bus_lock_n = ~(lock_reg || (start && (core_bus.locked || ack_seq)));

  // Branch pulse, always driven
  logic branch_reg;           // Registered branch event
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      branch_reg <= 1'h0;
    end else begin
      branch_reg <= branch_taken;
    end
  end
  assign branch_taken_pulse = branch_reg;

  // Internal error: one clock low, then shutdown until restart
  logic internal_error_flag_n_reg;             // Error pulse
  logic shut_reg;             // Shutdown held
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      internal_error_flag_n_reg <= 1'h0;
      shut_reg <= 1'h0;
    end else begin
      internal_error_flag_n_reg <= array_parity_err && !shut_reg && !internal_error_flag_n_reg;
      if (internal_error_flag_n_reg) begin
        shut_reg <= 1'h1;
      end else if (restart) begin
        shut_reg <= 1'h0;
      end
    end
  end
  assign internal_error_flag_n = ~internal_error_flag_n_reg;
  assign shutdown              = shut_reg;

  // Numeric fault gate
  logic bypass;               // Bypass honoured
  logic ctrl_op;              // One of the six control ops
  logic halt_reg;             // Waiting for interrupt
  assign bypass  = (fpu_fault_report_mode != CHIC_MODE_NATIVE) && !bypass_n_s;
  assign ctrl_op = (fpu_req.op != CHIC_OP_OTHER);
  always_comb begin
    fpu_issue_ok = 1'h1;
    if (!fpu_req.valid || halt_reg) begin
      fpu_issue_ok = 1'h0;
    end else if (pending_fpu_fault && !bypass && !ctrl_op) begin
      fpu_issue_ok = 1'h0;
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      halt_reg <= 1'h0;
    end else if (fpu_req.valid && !halt_reg && pending_fpu_fault && !bypass &&
                 !ctrl_op && (fpu_fault_report_mode != CHIC_MODE_NATIVE)) begin
      halt_reg <= 1'h1;
    end else if (irq_s || restart) begin
      halt_reg <= 1'h0;
    end
  end
  assign fpu_halted = halt_reg;

endmodule

// File: dv/chic_far_model.sv
// Purpose: Far side model: bus cycle responder and interrupt source.
// Assumes: Each started cycle gets one low ready clock after wait_cycles.
// Notes:   The irq stays raised until the first acknowledge cycle.
`timescale 1ns/100ps
module chic_far_model (
  input  wire logic       clock,            // Processor clock
  input  wire logic       bus_cycle_start,  // Cycle started by the block
  input  wire logic       irq_ack_cycle,    // Started cycle is an ack
  input  wire logic       irq_raise,        // Bench asks for an interrupt
  input  wire logic [3:0] wait_cycles,      // Responder delay
  output logic            burst_ready_in_n, // Cycle done, low
  output logic            maskable_irq_in   // Interrupt line
);
  logic [3:0] cnt_reg;   // Wait count
  logic       busy_reg;  // Cycle open
  initial begin
    burst_ready_in_n = 1'h1;
    maskable_irq_in = 1'h0;
    busy_reg = 1'h0;
    cnt_reg = 4'h0;
  end
  // Answer each cycle once, prompt or slow
  always @(posedge clock) begin
    burst_ready_in_n <= 1'h1;
    if (bus_cycle_start || irq_ack_cycle) begin
      busy_reg <= 1'h1;
      cnt_reg <= wait_cycles;
    end else if (busy_reg && cnt_reg != 4'h0) begin
      cnt_reg <= cnt_reg - 4'h1;
    end else if (busy_reg) begin
      busy_reg <= 1'h0;
      burst_ready_in_n <= 1'h0;
    end
  end
  // Hold the request until acknowledged
  always @(posedge clock) begin
    if (irq_ack_cycle) maskable_irq_in <= 1'h0;
    else if (irq_raise) maskable_irq_in <= 1'h1;
  end
endmodule

// File: dv/chic_ctrl_checker.sv
// Purpose: Port-level checks for the control-pin block.
// Assumes: Single clock domain; rstn is the only reset seen.
// Notes:   Sync latency of pin inputs is allowed for in the windows.
`timescale 1ns/100ps
module chic_ctrl_checker
  import chic_pkg::*;
(
  input wire logic          clock,
  input wire logic          rstn,
  input wire logic          bus_yield_req,
  input wire logic          bus_yield_grant,
  input wire logic          bus_float,
  input wire logic          bus_cycle_start,
  input wire logic          bus_lock_n,
  input wire logic          irq_ack_cycle,
  input wire logic          irq_vector,
  input wire logic          branch_taken,
  input wire logic          branch_taken_pulse,
  input wire logic          array_parity_err,
  input wire logic          internal_error_flag_n,
  input wire logic          shutdown,
  input wire chic_fpu_req_t fpu_req,
  input wire logic          fpu_issue_ok,
  input wire logic          fpu_halted,
  input wire logic          fpu_fault_report_mode,
  input wire logic          warm_restart,
  input wire logic          warm_restart_req
);
  logic [1:0] ack_cnt_reg;  // Acks since last vector
  default clocking cb_main @(posedge clock); endclocking
  default disable iff (!rstn);
  // Count acknowledge cycles per interrupt
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) ack_cnt_reg <= 2'h0;
    else if (irq_vector) ack_cnt_reg <= 2'h0;
    else if (irq_ack_cycle && ack_cnt_reg != 2'h3) ack_cnt_reg <= ack_cnt_reg + 2'h1;
  end
  property p_br_rise; branch_taken |=> branch_taken_pulse; endproperty
  a_br_rise: assert property (p_br_rise) else $error("branch pulse missing");
  property p_br_cause; branch_taken_pulse |-> $past(branch_taken); endproperty
  a_br_cause: assert property (p_br_cause) else $error("stray branch pulse");
  property p_err;
    array_parity_err && internal_error_flag_n && !shutdown |=> !internal_error_flag_n
      ##1 internal_error_flag_n ##[0:1] shutdown;
  endproperty
  a_err: assert property (p_err) else $error("error pulse or shutdown wrong");
  property p_y_lock; bus_yield_grant |-> bus_lock_n && bus_float; endproperty
  a_y_lock: assert property (p_y_lock) else $error("grant while locked");
  property p_y_hold;
    bus_yield_grant && bus_yield_req && $past(bus_yield_req) && $past(bus_yield_req, 2)
      |=> bus_yield_grant;
  endproperty
  a_y_hold: assert property (p_y_hold) else $error("grant dropped early");
  property p_y_rel; $fell(bus_yield_req) && bus_yield_grant |-> ##[1:5] !bus_yield_grant;
  endproperty
  a_y_rel: assert property (p_y_rel) else $error("grant not released");
  property p_ack_cnt; irq_vector |-> ack_cnt_reg == 2'h2; endproperty
  a_ack_cnt: assert property (p_ack_cnt) else $error("ack count wrong");
  property p_ack_lock; irq_ack_cycle |-> !bus_lock_n; endproperty
  a_ack_lock: assert property (p_ack_lock) else $error("ack not locked");
  property p_lock_start; $fell(bus_lock_n) |-> bus_cycle_start; endproperty
  a_lock_start: assert property (p_lock_start) else $error("lock without start");
  property p_fpu_ctl;
    fpu_req.valid && !fpu_halted && fpu_req.op != CHIC_OP_OTHER |-> fpu_issue_ok;
  endproperty
  a_fpu_ctl: assert property (p_fpu_ctl) else $error("control op blocked");
  property p_fpu_halt;
    fpu_req.valid && !fpu_halted && !fpu_issue_ok &&
      fpu_fault_report_mode != CHIC_MODE_NATIVE |=> fpu_halted;
  endproperty
  a_fpu_halt: assert property (p_fpu_halt) else $error("no halt");
  property p_warm; $rose(warm_restart) |-> ##[2:4] warm_restart_req; endproperty
  a_warm: assert property (p_warm) else $error("restart not seen");
endmodule
bind chic_ctrl chic_ctrl_checker u_chk (.clock(clock), .rstn(rstn),
  .bus_yield_req(bus_yield_req), .bus_yield_grant(bus_yield_grant), .bus_float(bus_float),
  .bus_cycle_start(bus_cycle_start), .bus_lock_n(bus_lock_n), .irq_ack_cycle(irq_ack_cycle),
  .irq_vector(irq_vector), .branch_taken(branch_taken),
  .branch_taken_pulse(branch_taken_pulse), .array_parity_err(array_parity_err),
  .internal_error_flag_n(internal_error_flag_n), .shutdown(shutdown), .fpu_req(fpu_req),
  .fpu_issue_ok(fpu_issue_ok), .fpu_halted(fpu_halted), .warm_restart(warm_restart),
  .fpu_fault_report_mode(fpu_fault_report_mode),
  .warm_restart_req(warm_restart_req));

// File: dv/chic_ctrl_bench.sv
// Purpose: Self-checking bench for the control-pin block.
// Assumes: Inputs change on the falling edge; far side is chic_far_model.
// Notes:   Op gating runs from a table; the rest is hand-written.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module chic_ctrl_bench;
  import chic_pkg::*;
  logic clock, rstn, bus_yield_req, burst_ready_in_n, branch_taken, array_parity_err;
  logic fpu_fault_report_mode, pending_fpu_fault, numeric_error_bypass_n, warm_restart;
  logic maskable_irq_in, irq_allow, insn_done, irq_raise, bus_yield_grant, bus_float;
  logic bus_cycle_start, bus_lock_n, irq_ack_cycle, branch_taken_pulse, shutdown;
  logic internal_error_flag_n, fpu_issue_ok, fpu_halted, warm_restart_req;
  logic self_test_req, irq_vector;
  logic [3:0] wait_cycles;  // Far side delay
  chic_bus_req_t core_bus;  // Core cycle request
  chic_fpu_req_t fpu_req;   // Numeric op request
  int n_mismatch = 0, cmp_count = 0, acks = 0, vecs = 0;
  // Row: mode, fault, bypass_n, valid, op, expected issue
  typedef struct { logic m, f, b, v; chic_fpu_op_t op; logic ok; } chic_row_t;
  chic_row_t rows[9] = '{'{0, 1, 1, 1, CHIC_OP_REINIT, 1}, '{0, 1, 1, 1, CHIC_OP_EXCCLR, 1},
    '{0, 1, 1, 1, CHIC_OP_ENVST, 1}, '{0, 1, 1, 1, CHIC_OP_SAVE, 1},
    '{0, 1, 1, 1, CHIC_OP_STATST, 1}, '{0, 1, 1, 1, CHIC_OP_CTRLST, 1},
    '{0, 1, 0, 1, CHIC_OP_OTHER, 1}, '{1, 1, 0, 1, CHIC_OP_OTHER, 0},
    '{0, 1, 1, 0, CHIC_OP_OTHER, 0}};
  chic_ctrl uut (.clock(clock), .rstn(rstn), .bus_yield_req(bus_yield_req),
    .bus_yield_grant(bus_yield_grant), .bus_float(bus_float), .core_bus(core_bus),
    .burst_ready_in_n(burst_ready_in_n), .bus_cycle_start(bus_cycle_start),
    .bus_lock_n(bus_lock_n), .irq_ack_cycle(irq_ack_cycle), .branch_taken(branch_taken),
    .branch_taken_pulse(branch_taken_pulse), .array_parity_err(array_parity_err),
    .internal_error_flag_n(internal_error_flag_n), .shutdown(shutdown),
    .fpu_fault_report_mode(fpu_fault_report_mode), .pending_fpu_fault(pending_fpu_fault),
    .numeric_error_bypass_n(numeric_error_bypass_n), .fpu_req(fpu_req),
    .fpu_issue_ok(fpu_issue_ok), .fpu_halted(fpu_halted), .warm_restart(warm_restart),
    .warm_restart_req(warm_restart_req), .self_test_req(self_test_req),
    .maskable_irq_in(maskable_irq_in), .irq_allow(irq_allow), .insn_done(insn_done),
    .irq_vector(irq_vector));
  chic_far_model far (.clock(clock), .bus_cycle_start(bus_cycle_start),
    .irq_ack_cycle(irq_ack_cycle), .irq_raise(irq_raise), .wait_cycles(wait_cycles),
    .burst_ready_in_n(burst_ready_in_n), .maskable_irq_in(maskable_irq_in));
  // 250 MHz clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // Tally acknowledge cycles and vectors
  always @(posedge clock) begin
    if (irq_ack_cycle === 1'b1) acks++;
    if (irq_vector === 1'b1) vecs++;
  end
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // One bus cycle: hold the request until it is started
  task automatic bus_op(input logic lk, input logic ls);
    int t;
    core_bus = '{1'b1, lk, ls};
    #1;
    for (t = 0; t < 50 && bus_cycle_start !== 1'b1; t++) cyc(1);
    cyc(1);
    core_bus = '0;
    cyc(1);
  endtask
  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    #10000;
    n_mismatch++;
    summarize();
  end
  initial begin
    {rstn, branch_taken, array_parity_err, fpu_fault_report_mode, pending_fpu_fault} = '0;
    {warm_restart, irq_allow, insn_done, irq_raise, core_bus, fpu_req} = '0;
    numeric_error_bypass_n = 1'b1;
    wait_cycles = 4'h0;
    bus_yield_req = 1'b1;
    cyc(10);
    `CHK("grant_in_reset", 1'b1, bus_yield_grant)
    rstn = 1'b1;
    bus_yield_req = 1'b0;
    cyc(6);
    `CHK("self_test_cold", 1'b0, self_test_req)
    foreach (rows[i]) begin
      {fpu_fault_report_mode, pending_fpu_fault} = {rows[i].m, rows[i].f};
      numeric_error_bypass_n = rows[i].b;
      fpu_req = '0;
      cyc(3);
      fpu_req = '{rows[i].v, rows[i].op};
      cyc(1);
      `CHK("issue_ok", rows[i].ok, fpu_issue_ok)
    end
    fpu_req = '{1'b1, CHIC_OP_OTHER};
    cyc(1);
    fpu_req = '0;
    `CHK("halted", 1'b1, fpu_halted)
    wait_cycles = 4'h3;
    insn_done = 1'b1;
    irq_raise = 1'b1;
    cyc(1);
    irq_raise = 1'b0;
    cyc(8);
    `CHK("halt_exit", 1'b0, fpu_halted)
    `CHK("no_ack", 0, acks)
    irq_allow = 1'b1;
    cyc(40);
    `CHK("ack_count", 2, acks)
    `CHK("vectors", 1, vecs)
    irq_allow = 1'b0;
    branch_taken = 1'b1;
    cyc(1);
    branch_taken = 1'b0;
    `CHK("branch_hi", 1'b1, branch_taken_pulse)
    cyc(1);
    `CHK("branch_lo", 1'b0, branch_taken_pulse)
    array_parity_err = 1'b1;
    cyc(1);
    array_parity_err = 1'b0;
    `CHK("err_lo", 1'b0, internal_error_flag_n)
    cyc(2);
    `CHK("err_hi", 1'b1, internal_error_flag_n)
    `CHK("shutdown", 1'b1, shutdown)
    warm_restart = 1'b1;
    cyc(5);
    warm_restart = 1'b0;
    `CHK("restart_clr", 1'b0, shutdown)
    wait_cycles = 4'h4;
    bus_op(1'b1, 1'b0);
    bus_yield_req = 1'b1;
    bus_op(1'b1, 1'b1);
    `CHK("no_grant_locked", 1'b0, bus_yield_grant)
    cyc(14);
    `CHK("grant", 1'b1, bus_yield_grant)
    `CHK("float", 1'b1, bus_float)
    core_bus = '{1'b1, 1'b0, 1'b0};
    cyc(3);
    `CHK("held", 1'b1, bus_yield_grant)
    bus_yield_req = 1'b0;
    for (int t = 0; t < 10 && bus_yield_grant === 1'b1; t++) cyc(1);
    `CHK("start_at_release", 1'b1, bus_cycle_start)
    cyc(1);
    core_bus = '0;
    cyc(10);
    rstn = 1'b0;
    warm_restart = 1'b1;
    cyc(3);
    rstn = 1'b1;
    cyc(5);
    `CHK("self_test", 1'b1, self_test_req)
    summarize();
  end
endmodule
